// file: pbcs_pkg.sv
// Package with register indexes, field positions and reset values of the PHY basic registers.
package pbcs_pkg;

    // ****************************************
    // Register indexes
    // ****************************************
    localparam logic [4:0] PBCS_IDX_CONTROL = 5'h00;
    localparam logic [4:0] PBCS_IDX_STATUS = 5'h01;
    localparam logic [4:0] PBCS_IDX_ID1 = 5'h02;
    localparam logic [4:0] PBCS_IDX_ID2 = 5'h03;
    localparam logic [4:0] PBCS_IDX_ANADV = 5'h04;
    localparam logic [4:0] PBCS_IDX_ANLPA = 5'h05;
    localparam logic [4:0] PBCS_IDX_ANEXP = 5'h06;
    localparam logic [4:0] PBCS_IDX_MODE = 5'h11;
    localparam logic [4:0] PBCS_IDX_SPMODE = 5'h12;
    localparam logic [4:0] PBCS_IDX_SPCTL = 5'h1B;
    localparam logic [4:0] PBCS_IDX_INTSRC = 5'h1D;
    localparam logic [4:0] PBCS_IDX_INTMSK = 5'h1E;
    localparam logic [4:0] PBCS_IDX_PHYSPC = 5'h1F;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int PBCS_CTL_RESET = 15;
    localparam int PBCS_CTL_LOOPBACK = 14;
    localparam int PBCS_CTL_SPEED = 13;
    localparam int PBCS_CTL_ANEN = 12;
    localparam int PBCS_CTL_PDOWN = 11;
    localparam int PBCS_CTL_RESTART = 9;
    localparam int PBCS_CTL_DUPLEX = 8;
    localparam int PBCS_CTL_COLTEST = 7;

    // ****************************************
    // Status register fields and constant value
    // ****************************************
    localparam int PBCS_STS_ANDONE = 5;
    localparam int PBCS_STS_RFAULT = 4;
    localparam int PBCS_STS_LINK = 2;
    localparam int PBCS_STS_JABBER = 1;
    localparam logic [15:0] PBCS_STS_FIXED = 16'h7809;

    // ****************************************
    // Reset values and soft reset length
    // ****************************************
    localparam logic PBCS_RST_LOOPBACK = 1'h0;
    localparam logic PBCS_RST_PDOWN = 1'h0;
    localparam logic PBCS_RST_DUPLEX = 1'h0;
    localparam logic PBCS_RST_COLTEST = 1'h0;
    localparam int PBCS_SOFT_RESET_CYCLES = 4;

    typedef enum logic [1:0] {
        PBCS_RS_IDLE = 2'b00,
        PBCS_RS_HOLD = 2'b01
    } pbcs_rst_state_t;

endpackage

// file: pbcs_latch_if.sv
// Interface carrying live conditions and read strobe into the latched status bit module.
`timescale 1ns/1ps
`default_nettype none
interface pbcs_latch_if;
    logic [2:0] live;
    logic rd_strobe;
    logic clr;
    logic [2:0] held;
    modport ctrl (output live, output rd_strobe, output clr, input held);
    modport lat (input live, input rd_strobe, input clr, output held);
endinterface
`default_nettype wire

// file: pbcs_latch.sv
// Latching status bits: bit 0 latches low, bits 1 and 2 latch high until the register is read.
`timescale 1ns/1ps
`default_nettype none
module pbcs_latch (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Latch carrier
    pbcs_latch_if.lat lif
);
    import pbcs_pkg::*;

    logic [2:0] held_q;
    logic [2:0] held_d;
    logic [2:0] armed_q;
    logic [2:0] armed_d;

    // Bit 0 is the link, bits 1 and 2 are jabber and remote fault.
    always_comb begin
        held_d = held_q;
        armed_d = armed_q;
        if (lif.clr) begin
            held_d = {lif.live[2:1], 1'b0};
            armed_d = 3'h0;
        end else begin
            // The read unlatches; an event in the read cycle is kept.
            if (lif.live[0] == 1'b0) begin
                held_d[0] = 1'b0;
                armed_d[0] = 1'b1;
            end else if (!armed_q[0] || lif.rd_strobe) begin
                held_d[0] = 1'b1;
                armed_d[0] = 1'b0;
            end
            for (int i = 1; i < 3; i++) begin
                if (lif.live[i]) begin
                    held_d[i] = 1'b1;
                end else if (lif.rd_strobe) begin
                    held_d[i] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            held_q <= 3'h0;
            armed_q <= 3'h0;
        end else begin
            held_q <= held_d;
            armed_q <= armed_d;
        end
    end

    assign lif.held = held_q;
endmodule
`default_nettype wire

// file: pbcs_regs.sv
// Basic control and status registers of the PHY, reached through indexed management accesses.
//
// Function
// - Registers are reached only through indexed management commands, never memory mapped.
// - Indexes 0-6, 17, 18, 27, 29, 30, 31 are decoded as PHY registers.
// - Kept-through-soft-reset fields survive only the control bit 15 reset; no control field is kept here, all return to reset values.
// - Writing control bit 15 starts a soft reset; the bit clears itself.
// - Control bit 14 selects loopback; resets to 0.
// - Control bit 13 selects 100 or 10 Mbps, ignored while auto-negotiation enabled.
// - Control bit 12 enables auto-negotiation, overriding speed and duplex bits.
// - Speed and auto-negotiation enable reset values come from the speed strap.
// - Control bit 11 powers down; after clearing, negotiation may complete later.
// - Writing control bit 9 restarts auto-negotiation; the bit clears itself.
// - Control bit 8 selects full or half duplex, ignored during auto-negotiation.
// - Control bit 7 enables the collision test; resets to 0.
// - Status bit 15 reads 0; bits 14 to 11 read 1.
// - Status bit 5 shows auto-negotiation completion.
// - Status bit 4 latches a remote fault high.
// - Status bit 3 reads constant 1.
// - Status bit 2 shows link, latching low; resets to 0.
// - Status bit 1 latches jabber high.
// - Status bit 0 reads constant 1.
`timescale 1ns/1ps
`default_nettype none
module pbcs_regs #(
    parameter int SOFT_RESET_CYCLES = pbcs_pkg::PBCS_SOFT_RESET_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Management access from the MAC
    input wire logic MGMT_REQ,
    input wire logic MGMT_WRITE,
    input wire logic [4:0] MGMT_INDEX,
    input wire logic [15:0] MGMT_WDATA,
    output logic MGMT_ACK,
    output logic [15:0] MGMT_RDATA,
    output logic MGMT_HIT,
    // Straps and live PHY conditions
    input wire logic SPEED_SEL,
    input wire logic AN_COMPLETE,
    input wire logic REMOTE_FAULT,
    input wire logic LINK_UP,
    input wire logic JABBER,
    input wire logic [15:0] OTHER_RDATA,
    // PHY controls
    output logic SOFT_RESET,
    output logic LOOPBACK,
    output logic SPEED_100,
    output logic FULL_DUPLEX,
    output logic AN_ENABLE,
    output logic AN_RESTART,
    output logic POWER_DOWN,
    output logic COL_TEST
);
    import pbcs_pkg::*;

    localparam logic [7:0] SR_LAST = 8'(SOFT_RESET_CYCLES - 1);

    // ****************************************
    // State
    // ****************************************
    logic loop_q;
    logic loop_d;
    logic spd_q;
    logic spd_d;
    logic anen_q;
    logic anen_d;
    logic pd_q;
    logic pd_d;
    logic dup_q;
    logic dup_d;
    logic col_q;
    logic col_d;
    logic rst_bit_q;
    logic rst_bit_d;
    logic rstrt_q;
    logic rstrt_d;
    logic strap_q;
    logic strap_d;
    logic strap_done_q;
    logic strap_done_d;
    pbcs_rst_state_t rs_q;
    pbcs_rst_state_t rs_d;
    logic [7:0] rcnt_q;
    logic [7:0] rcnt_d;
    logic ack_q;
    logic ack_d;
    logic hit_q;
    logic hit_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic sp100_q;
    logic sp100_d;
    logic fdx_q;
    logic fdx_d;
    logic [15:0] ctl_view;
    logic [15:0] sts_view;
    logic known;
    logic wr_ctl;
    logic rd_sts;
    logic soft_clr;

    pbcs_latch_if lif ();

    pbcs_latch u_latch (
        .clk(CLK),
        .reset_n(RESET_N),
        .lif(lif)
    );

    // ****************************************
    // Decode
    // ****************************************
    always_comb begin
        case (MGMT_INDEX)
            PBCS_IDX_CONTROL,
            PBCS_IDX_STATUS,
            PBCS_IDX_ID1,
            PBCS_IDX_ID2,
            PBCS_IDX_ANADV,
            PBCS_IDX_ANLPA,
            PBCS_IDX_ANEXP,
            PBCS_IDX_MODE,
            PBCS_IDX_SPMODE,
            PBCS_IDX_SPCTL,
            PBCS_IDX_INTSRC,
            PBCS_IDX_INTMSK,
            PBCS_IDX_PHYSPC: known = 1'b1;
            default: known = 1'b0;
        endcase
    end

    // Only index 0 writes and index 1 reads touch state in this block.
    assign wr_ctl = MGMT_REQ && MGMT_WRITE && (MGMT_INDEX == PBCS_IDX_CONTROL);
    assign rd_sts = MGMT_REQ && !MGMT_WRITE && (MGMT_INDEX == PBCS_IDX_STATUS);
    assign soft_clr = (rs_q == PBCS_RS_HOLD) && (rcnt_q == SR_LAST);

    // ****************************************
    // Latch hookup
    // ****************************************
    // The end of a soft reset also clears latched bit 0 and loads bits 1 and 2 with their live levels.
    assign lif.live = {REMOTE_FAULT, JABBER, LINK_UP};
    assign lif.rd_strobe = rd_sts;
    assign lif.clr = soft_clr;

    // ****************************************
    // Register views
    // ****************************************
    always_comb begin
        ctl_view = 16'h0000;
        ctl_view[PBCS_CTL_RESET] = rst_bit_q;
        ctl_view[PBCS_CTL_LOOPBACK] = loop_q;
        ctl_view[PBCS_CTL_SPEED] = spd_q;
        ctl_view[PBCS_CTL_ANEN] = anen_q;
        ctl_view[PBCS_CTL_PDOWN] = pd_q;
        // The restart pulse is issued at once, so bit 9 always reads back as 0.
        ctl_view[PBCS_CTL_RESTART] = 1'b0;
        ctl_view[PBCS_CTL_DUPLEX] = dup_q;
        ctl_view[PBCS_CTL_COLTEST] = col_q;
    end

    always_comb begin
        sts_view = PBCS_STS_FIXED;
        sts_view[PBCS_STS_ANDONE] = AN_COMPLETE && anen_q && !pd_q;
        sts_view[PBCS_STS_RFAULT] = lif.held[2];
        sts_view[PBCS_STS_LINK] = lif.held[0];
        sts_view[PBCS_STS_JABBER] = lif.held[1];
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        loop_d = loop_q;
        spd_d = spd_q;
        anen_d = anen_q;
        pd_d = pd_q;
        dup_d = dup_q;
        col_d = col_q;
        rst_bit_d = rst_bit_q;
        rstrt_d = 1'b0;
        strap_d = strap_q;
        strap_done_d = strap_done_q;
        rs_d = rs_q;
        rcnt_d = rcnt_q;
        // The strap level is caught on the first clock after reset release.
        if (!strap_done_q) begin
            strap_done_d = 1'b1;
            strap_d = SPEED_SEL;
            spd_d = SPEED_SEL;
            anen_d = SPEED_SEL;
        end
        if (wr_ctl && rs_q == PBCS_RS_IDLE) begin
            loop_d = MGMT_WDATA[PBCS_CTL_LOOPBACK];
            spd_d = MGMT_WDATA[PBCS_CTL_SPEED];
            anen_d = MGMT_WDATA[PBCS_CTL_ANEN];
            pd_d = MGMT_WDATA[PBCS_CTL_PDOWN];
            dup_d = MGMT_WDATA[PBCS_CTL_DUPLEX];
            col_d = MGMT_WDATA[PBCS_CTL_COLTEST];
            rstrt_d = MGMT_WDATA[PBCS_CTL_RESTART];
            if (MGMT_WDATA[PBCS_CTL_RESET]) begin
                rst_bit_d = 1'b1;
                rs_d = PBCS_RS_HOLD;
                rcnt_d = 8'h00;
            end
        end
        case (rs_q)
            PBCS_RS_IDLE: begin
            end
            PBCS_RS_HOLD: begin
                rcnt_d = rcnt_q + 8'h01;
                if (soft_clr) begin
                    // No field is kept here, so all return to reset values.
                    rs_d = PBCS_RS_IDLE;
                    rst_bit_d = 1'b0;
                    loop_d = PBCS_RST_LOOPBACK;
                    pd_d = PBCS_RST_PDOWN;
                    dup_d = PBCS_RST_DUPLEX;
                    col_d = PBCS_RST_COLTEST;
                    spd_d = strap_q;
                    anen_d = strap_q;
                end
            end
            default: rs_d = PBCS_RS_IDLE;
        endcase
        // Manual speed and duplex apply only while negotiation is off.
        sp100_d = anen_d ? sp100_q : spd_d;
        fdx_d = anen_d ? fdx_q : dup_d;
        ack_d = MGMT_REQ;
        hit_d = MGMT_REQ && known;
        rdata_d = 16'h0000;
        if (MGMT_REQ && !MGMT_WRITE) begin
            case (MGMT_INDEX)
                PBCS_IDX_CONTROL: rdata_d = ctl_view;
                PBCS_IDX_STATUS: rdata_d = sts_view;
                default: rdata_d = known ? OTHER_RDATA : 16'h0000;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            loop_q <= PBCS_RST_LOOPBACK;
            spd_q <= 1'b0;
            anen_q <= 1'b0;
            pd_q <= PBCS_RST_PDOWN;
            dup_q <= PBCS_RST_DUPLEX;
            col_q <= PBCS_RST_COLTEST;
            rst_bit_q <= 1'b0;
            rstrt_q <= 1'b0;
            strap_q <= 1'b0;
            strap_done_q <= 1'b0;
            rs_q <= PBCS_RS_IDLE;
            rcnt_q <= 8'h00;
            ack_q <= 1'b0;
            hit_q <= 1'b0;
            rdata_q <= 16'h0000;
            sp100_q <= 1'b0;
            fdx_q <= 1'b0;
        end else begin
            loop_q <= loop_d;
            spd_q <= spd_d;
            anen_q <= anen_d;
            pd_q <= pd_d;
            dup_q <= dup_d;
            col_q <= col_d;
            rst_bit_q <= rst_bit_d;
            rstrt_q <= rstrt_d;
            strap_q <= strap_d;
            strap_done_q <= strap_done_d;
            rs_q <= rs_d;
            rcnt_q <= rcnt_d;
            ack_q <= ack_d;
            hit_q <= hit_d;
            rdata_q <= rdata_d;
            sp100_q <= sp100_d;
            fdx_q <= fdx_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign MGMT_ACK = ack_q;
    assign MGMT_HIT = hit_q;
    assign MGMT_RDATA = rdata_q;
    assign SOFT_RESET = rst_bit_q;
    assign LOOPBACK = loop_q;
    assign SPEED_100 = sp100_q;
    assign FULL_DUPLEX = fdx_q;
    assign AN_ENABLE = anen_q;
    assign AN_RESTART = rstrt_q;
    assign POWER_DOWN = pd_q;
    assign COL_TEST = col_q;
endmodule
`default_nettype wire

// file: pbcs_regs_asserts.sv
// Checker of the basic control and status register block at its ports.
`timescale 1ns/1ps
`default_nettype none
module pbcs_regs_asserts #(
    parameter int SOFT_RESET_CYCLES = pbcs_pkg::PBCS_SOFT_RESET_CYCLES
) (
    // Clock, reset and management access
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic MGMT_REQ,
    input wire logic MGMT_WRITE,
    input wire logic [4:0] MGMT_INDEX,
    input wire logic [15:0] MGMT_WDATA,
    input wire logic MGMT_ACK,
    input wire logic [15:0] MGMT_RDATA,
    input wire logic MGMT_HIT,
    // Conditions and controls
    input wire logic SPEED_SEL,
    input wire logic AN_COMPLETE,
    input wire logic REMOTE_FAULT,
    input wire logic LINK_UP,
    input wire logic JABBER,
    input wire logic [15:0] OTHER_RDATA,
    input wire logic SOFT_RESET,
    input wire logic LOOPBACK,
    input wire logic SPEED_100,
    input wire logic FULL_DUPLEX,
    input wire logic AN_ENABLE,
    input wire logic AN_RESTART,
    input wire logic POWER_DOWN,
    input wire logic COL_TEST
);
    import pbcs_pkg::*;
    logic [4:0] idx_q;
    logic wr_q;
    logic [15:0] wd_q;
    logic rd_sts;
    always_ff @(posedge CLK) begin
        idx_q <= MGMT_INDEX;
        wr_q <= MGMT_WRITE;
        wd_q <= MGMT_WDATA;
    end
    assign rd_sts = MGMT_ACK && !wr_q && idx_q == 5'h01;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    AST_ACK: assert property (MGMT_REQ |=> MGMT_ACK && (MGMT_HIT || MGMT_RDATA == 16'h0000))
        else $error("no ack after request");
    AST_QUIET: assert property (!$past(MGMT_REQ) |-> !MGMT_ACK && !MGMT_HIT)
        else $error("ack without request");
    AST_HIT: assert property (MGMT_ACK |-> MGMT_HIT == (idx_q <= 5'h06
        || idx_q inside {5'h11, 5'h12, 5'h1B, 5'h1D, 5'h1E, 5'h1F}))
        else $error("index decode wrong");
    AST_STS_FIXED: assert property (rd_sts |-> (MGMT_RDATA & 16'hFFC9) == PBCS_STS_FIXED)
        else $error("status fixed bits wrong");
    AST_CTL_ZERO: assert property (MGMT_ACK && !wr_q && idx_q == 5'h00
        |-> (MGMT_RDATA & 16'h067F) == 16'h0000)
        else $error("control zero bits set");
    AST_CTL_APPLY: assert property (MGMT_ACK && wr_q && idx_q == 5'h00
        && !$past(SOFT_RESET) && !wd_q[15] |-> LOOPBACK == wd_q[14] && AN_ENABLE == wd_q[12]
        && POWER_DOWN == wd_q[11] && COL_TEST == wd_q[7])
        else $error("control write not applied");
    AST_SOFT_END: assert property ($rose(SOFT_RESET) |-> ##[1:16] !SOFT_RESET)
        else $error("soft reset stuck");
    AST_SOFT_RESTORE: assert property ($fell(SOFT_RESET)
        |-> ##[0:1] !LOOPBACK && !POWER_DOWN && !COL_TEST)
        else $error("controls not restored");
    AST_RESTART: assert property (AN_RESTART && !(MGMT_REQ && MGMT_WRITE
        && MGMT_INDEX == 5'h00 && MGMT_WDATA[9]) |=> !AN_RESTART)
        else $error("restart not self clearing");
    AST_HOLD: assert property (AN_ENABLE && $past(AN_ENABLE) && !SOFT_RESET
        && !$past(SOFT_RESET) |-> $stable(SPEED_100) && $stable(FULL_DUPLEX))
        else $error("speed or duplex moved");
    AST_JAB: assert property (rd_sts && $past(JABBER, 2) |-> MGMT_RDATA[1])
        else $error("jabber not latched");
    AST_LINK: assert property (rd_sts && !$past(LINK_UP, 2) |-> !MGMT_RDATA[2])
        else $error("link loss not latched");
    cover property (rd_sts && MGMT_RDATA[5]);
    cover property ($fell(SOFT_RESET));
    cover property (AN_RESTART);
endmodule
bind pbcs_regs pbcs_regs_asserts #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) u_chk (
    .CLK(CLK), .RESET_N(RESET_N), .MGMT_REQ(MGMT_REQ), .MGMT_WRITE(MGMT_WRITE),
    .MGMT_INDEX(MGMT_INDEX), .MGMT_WDATA(MGMT_WDATA), .MGMT_ACK(MGMT_ACK),
    .MGMT_RDATA(MGMT_RDATA), .MGMT_HIT(MGMT_HIT), .SPEED_SEL(SPEED_SEL),
    .AN_COMPLETE(AN_COMPLETE), .REMOTE_FAULT(REMOTE_FAULT), .LINK_UP(LINK_UP),
    .JABBER(JABBER), .OTHER_RDATA(OTHER_RDATA), .SOFT_RESET(SOFT_RESET),
    .LOOPBACK(LOOPBACK), .SPEED_100(SPEED_100), .FULL_DUPLEX(FULL_DUPLEX),
    .AN_ENABLE(AN_ENABLE), .AN_RESTART(AN_RESTART), .POWER_DOWN(POWER_DOWN),
    .COL_TEST(COL_TEST));
`default_nettype wire

// file: pbcs_mac_model.sv
// Model of the MAC side that issues indexed management accesses.
`timescale 1ns/1ps
`default_nettype none
module pbcs_mac_model (
    // Clock
    input wire logic clk,
    // Management access
    output logic req,
    output logic wr,
    output logic [4:0] idx,
    output logic [15:0] wd,
    input wire logic ack,
    input wire logic [15:0] rd,
    input wire logic hit
);
    initial begin
        req = 1'b0;
        wr = 1'b0;
        idx = 5'h00;
        wd = 16'h0000;
    end
    // Issues one indexed access at a falling edge and takes the answer a cycle later.
    task automatic acc(input logic w, input logic [4:0] i, input logic [15:0] d,
                       output logic a, output logic [15:0] r, output logic h);
        req = 1'b1;
        wr = w;
        idx = i;
        wd = d;
        @(negedge clk);
        a = ack;
        r = rd;
        h = hit;
    endtask
    // Released lines are scrambled so that no stale value looks valid.
    task automatic idle();
        req = 1'b0;
        wr = ~wr;
        idx = ~idx;
        wd = ~wd;
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking testbench of the basic control and status register block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pbcs_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic req, wr, ack, hit, a, h;
    logic [4:0] idx;
    logic [15:0] wd, rd, r;
    logic an_done = 1'b0, rfault = 1'b0, link_up = 1'b0, jabber = 1'b0;
    logic speed_sel = 1'b1;
    logic soft_rst, loopback, speed_100, full_dup, an_en, an_rst, pdown, col_test;
    int bad_count = 0, check_count = 0, cyc = 0;
    always #10 clk = ~clk;
    pbcs_regs #(.SOFT_RESET_CYCLES(4)) u_dut (.CLK(clk), .RESET_N(reset_n),
        .MGMT_REQ(req), .MGMT_WRITE(wr), .MGMT_INDEX(idx), .MGMT_WDATA(wd),
        .MGMT_ACK(ack), .MGMT_RDATA(rd), .MGMT_HIT(hit), .SPEED_SEL(speed_sel),
        .AN_COMPLETE(an_done), .REMOTE_FAULT(rfault), .LINK_UP(link_up), .JABBER(jabber),
        .OTHER_RDATA(16'hA5C3), .SOFT_RESET(soft_rst), .LOOPBACK(loopback),
        .SPEED_100(speed_100), .FULL_DUPLEX(full_dup), .AN_ENABLE(an_en),
        .AN_RESTART(an_rst), .POWER_DOWN(pdown), .COL_TEST(col_test));
    pbcs_mac_model u_mac (.clk(clk), .req(req), .wr(wr), .idx(idx), .wd(wd),
        .ack(ack), .rd(rd), .hit(hit));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic one(input logic w, input logic [4:0] i, input logic [15:0] d);
        u_mac.acc(w, i, d, a, r, h);
        u_mac.idle();
        chk("ack", 16'h0001, {15'h0000, a});
    endtask
    task automatic outs(input logic [5:0] e);
        chk("controls", {10'h000, e}, {10'h000, loopback, speed_100, an_en, pdown,
            full_dup, col_test});
    endtask
    task automatic t_reset();
        one(1'b0, PBCS_IDX_CONTROL, 16'h0000);
        chk("ctl reset", 16'h3000, r);
        one(1'b0, PBCS_IDX_STATUS, 16'h0000);
        chk("sts reset", PBCS_STS_FIXED, r);
    endtask
    task automatic t_decode();
        logic e;
        for (int i = 0; i < 32; i++) begin
            e = (i <= 6) || (i inside {17, 18, 27, 29, 30, 31});
            u_mac.acc(1'b0, i[4:0], 16'h0000, a, r, h);
            chk("hit", {15'h0000, e}, {15'h0000, h});
            if (i > 1) chk("other", e ? 16'hA5C3 : 16'h0000, r);
        end
        u_mac.idle();
    endtask
    task automatic t_ctl();
        one(1'b1, PBCS_IDX_CONTROL, 16'h6DFF);
        outs(6'h37);
        one(1'b0, PBCS_IDX_CONTROL, 16'h0000);
        chk("ctl rd", 16'h6980, r);
        one(1'b1, PBCS_IDX_CONTROL, 16'h1000);
        outs(6'h1A);
        u_mac.acc(1'b1, PBCS_IDX_CONTROL, 16'h1200, a, r, h);
        chk("restart", 16'h0001, {15'h0000, an_rst});
        u_mac.idle();
        chk("restart end", 16'h0000, {15'h0000, an_rst});
        one(1'b0, PBCS_IDX_CONTROL, 16'h0000);
        chk("ctl rd2", 16'h1000, r);
        one(1'b1, PBCS_IDX_CONTROL, 16'h0100);
        outs(6'h02);
    endtask
    task automatic t_soft();
        u_mac.acc(1'b1, PBCS_IDX_CONTROL, 16'h8000, a, r, h);
        chk("soft on", 16'h0001, {15'h0000, soft_rst});
        u_mac.acc(1'b1, PBCS_IDX_CONTROL, 16'h4800, a, r, h);
        u_mac.idle();
        chk("refused", 16'h0000, {15'h0000, loopback});
        for (int k = 0; k < 20 && soft_rst; k++) @(negedge clk);
        chk("soft off", 16'h0000, {15'h0000, soft_rst});
        one(1'b0, PBCS_IDX_CONTROL, 16'h0000);
        chk("ctl soft", 16'h3000, r);
    endtask
    task automatic t_status();
        an_done = 1'b1;
        one(1'b0, PBCS_IDX_STATUS, 16'h0000);
        chk("an done", 16'h7829, r & 16'hFFFB);
        one(1'b1, PBCS_IDX_CONTROL, 16'h1800);
        one(1'b0, PBCS_IDX_STATUS, 16'h0000);
        chk("pdown", 16'h7809, r & 16'hFFFB);
        one(1'b1, PBCS_IDX_CONTROL, 16'h1000);
        {link_up, jabber, rfault} = 3'h7;
        repeat (2) @(negedge clk);
        {jabber, rfault} = 2'h0;
        repeat (2) @(negedge clk);
        one(1'b0, PBCS_IDX_STATUS, 16'h0000);
        chk("latch hi", 16'h783B, r & 16'hFFFB);
        one(1'b0, PBCS_IDX_STATUS, 16'h0000);
        chk("cleared", 16'h782D, r);
        link_up = 1'b0;
        repeat (2) @(negedge clk);
        link_up = 1'b1;
        repeat (2) @(negedge clk);
        one(1'b0, PBCS_IDX_STATUS, 16'h0000);
        chk("link lost", 16'h7829, r);
        one(1'b0, PBCS_IDX_STATUS, 16'h0000);
        chk("link back", 16'h782D, r);
    endtask
    task automatic t_strap();
        speed_sel = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        outs(6'h00);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        one(1'b0, PBCS_IDX_CONTROL, 16'h0000);
        chk("ctl strap", 16'h0000, r);
        one(1'b0, PBCS_IDX_STATUS, 16'h0000);
        chk("sts strap", 16'h780D, r);
        one(1'b1, PBCS_IDX_CONTROL, 16'h3000);
        one(1'b1, PBCS_IDX_CONTROL, 16'h8000);
        for (int k = 0; k < 20 && soft_rst; k++) @(negedge clk);
        one(1'b0, PBCS_IDX_CONTROL, 16'h0000);
        chk("ctl strap soft", 16'h0000, r);
        jabber = 1'b1;
        @(negedge clk);
        one(1'b0, PBCS_IDX_STATUS, 16'h0000);
        jabber = 1'b0;
        chk("jab live", 16'h780F, r);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        t_reset();
        t_decode();
        t_ctl();
        t_soft();
        t_status();
        t_strap();
        wrap_up();
    end
endmodule
`default_nettype wire
